// ===== src/cfg_ref_consts.svh
`ifndef CFG_REF_CONSTS_SVH
`define CFG_REF_CONSTS_SVH
`define OFF_OTP_WORD0 8'h00
`define OFF_INPUT_SRC 8'h13
`define BIT_I2C_DEFAULT 7
`define BIT_PRIM_SWAP 1
`define SM_LSB 2
`define RST_OTP_WORD0 8'h00
`define RST_INPUT_SRC 8'h00
`define SETTLE_MS 10
`define CLK_MHZ 100
`define SETTLE_CYCLES (`SETTLE_MS * 1000 * `CLK_MHZ)
`define LOAD_CYCLES 16
`endif

// ===== src/cfg_ref_pkg.sv
package cfg_ref_pkg;
  typedef enum logic [2:0] {CFG_0, CFG_1, CFG_2, CFG_3, CFG_I2C_DEFAULT} cfg_sel_t;
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_wr_t;
endpackage

// ===== src/config_ref_select.sv
`timescale 1ns/1ps
`include "cfg_ref_consts.svh"
module config_ref_select #(
  parameter int SETTLE_CYCLES = `SETTLE_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic config_strap_refout_in,
  output logic config_strap_refout_out,
  output logic config_strap_refout_oe,
  input wire logic cfg_select_hi,
  input wire logic cfg_select_lo,
  input wire logic ref_input_select,
  input wire logic ref_clk_in,
  input wire cfg_ref_pkg::reg_wr_t reg_wr,
  output logic serial_enable,
  output logic serial_ready,
  output logic load_strobe,
  output cfg_ref_pkg::cfg_sel_t active_config,
  output logic ref_diff_selected,
  output logic [7:0] otp_config_word_zero,
  output logic [7:0] input_source_config
);
  logic [1:0] sel_meta_reg, sel_sync_reg, sel_prev_reg;
  logic strap_meta_reg, strap_sync_reg, insel_meta_reg, insel_sync_reg;
  logic sampled_reg, sampled_next, strap_reg, strap_next;
  logic [31:0] settle_reg, settle_next;
  logic [4:0] load_cnt_reg, load_cnt_next;
  logic loaded_reg, loaded_next, load_reg, load_next;
  cfg_ref_pkg::cfg_sel_t cfg_reg, cfg_next;
  logic [7:0] word0_reg, word0_next, src_reg, src_next;
  logic diff_reg, diff_next, refout_reg;
  logic settled, want_diff;

  // Select, strap and input-select pins are asynchronous to clock, so each goes through two stages; ref_clk_in gets one.
  always_ff @(posedge clock) begin
    sel_meta_reg <= {cfg_select_hi, cfg_select_lo};
    sel_sync_reg <= sel_meta_reg;
    strap_meta_reg <= config_strap_refout_in;
    strap_sync_reg <= strap_meta_reg;
    insel_meta_reg <= ref_input_select;
    insel_sync_reg <= insel_meta_reg;
    sel_prev_reg <= sel_sync_reg;
  end

  function automatic cfg_ref_pkg::cfg_sel_t pick_config(input logic strap, input logic flag,
                                                        input logic [1:0] sel);
    if (strap) begin
      pick_config = cfg_ref_pkg::cfg_sel_t'({1'b0, sel});
    end else if (flag) begin
      pick_config = cfg_ref_pkg::CFG_I2C_DEFAULT;
    end else begin
      pick_config = cfg_ref_pkg::CFG_0;
    end
  endfunction

  assign settled = (settle_reg >= 32'(SETTLE_CYCLES));
  assign want_diff = insel_sync_reg ^ src_reg[`BIT_PRIM_SWAP];

  always_comb begin
    sampled_next = 1'b1;
    strap_next = sampled_reg ? strap_reg : strap_sync_reg;
    settle_next = settled ? settle_reg : settle_reg + 32'd1;
    load_next = 1'b0;
    cfg_next = cfg_reg;
    load_cnt_next = load_cnt_reg;
    loaded_next = loaded_reg;
    word0_next = word0_reg;
    src_next = src_reg;
    diff_next = diff_reg;
    if (sampled_reg && !loaded_reg) begin
      // Copy stored configuration before the serial port answers.
      if (load_cnt_reg == 5'(`LOAD_CYCLES)) begin
        loaded_next = 1'b1;
        load_next = 1'b1;
        cfg_next = pick_config(strap_reg, word0_reg[`BIT_I2C_DEFAULT], sel_sync_reg);
      end else begin
        load_cnt_next = load_cnt_reg + 5'd1;
      end
    end else if (loaded_reg && strap_reg && settled && !word0_reg[`BIT_I2C_DEFAULT]
                 && sel_sync_reg != sel_prev_reg) begin
      load_next = 1'b1;
      cfg_next = pick_config(1'b1, 1'b0, sel_sync_reg);
    end
    if (reg_wr.we && loaded_reg && !strap_reg) begin
      if (reg_wr.addr == `OFF_OTP_WORD0) begin
        word0_next = reg_wr.wdata;
      end
      if (reg_wr.addr == `OFF_INPUT_SRC) begin
        src_next = reg_wr.wdata;
      end
    end
    // Switch only while the reference is low so no runt pulse appears.
    if (!src_reg[`SM_LSB + 1] && !refout_reg) begin
      diff_next = want_diff;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sampled_reg <= 1'b0;
      strap_reg <= 1'b0;
      settle_reg <= 32'h0;
      load_cnt_reg <= 5'h0;
      loaded_reg <= 1'b0;
      load_reg <= 1'b0;
      cfg_reg <= cfg_ref_pkg::CFG_0;
      word0_reg <= `RST_OTP_WORD0;
      src_reg <= `RST_INPUT_SRC;
      diff_reg <= 1'b0;
      refout_reg <= 1'b0;
    end else begin
      sampled_reg <= sampled_next;
      strap_reg <= strap_next;
      settle_reg <= settle_next;
      load_cnt_reg <= load_cnt_next;
      loaded_reg <= loaded_next;
      load_reg <= load_next;
      cfg_reg <= cfg_next;
      word0_reg <= word0_next;
      src_reg <= src_next;
      diff_reg <= diff_next;
      refout_reg <= ref_clk_in;
    end
  end

  // The pin is an input during sampling and becomes the reference output after.
  always_ff @(posedge clock) begin
    if (rst) begin
      config_strap_refout_out <= 1'b0;
      config_strap_refout_oe <= 1'b0;
      serial_enable <= 1'b0;
      serial_ready <= 1'b0;
    end else begin
      config_strap_refout_out <= refout_reg;
      config_strap_refout_oe <= sampled_reg;
      serial_enable <= sampled_reg && !strap_reg;
      serial_ready <= loaded_reg && !strap_reg;
    end
  end

  assign load_strobe = load_reg;
  assign active_config = cfg_reg;
  assign ref_diff_selected = diff_reg;
  assign otp_config_word_zero = word0_reg;
  assign input_source_config = src_reg;

  property p_strap_held;
    @(posedge clock) disable iff (rst)
      sampled_reg && $past(sampled_reg) |-> $stable(strap_reg);
  endproperty
  a_strap_held: assert property (p_strap_held) else $error("strap changed after sampling");

  property p_hw_no_serial;
    @(posedge clock) disable iff (rst)
      sampled_reg && strap_reg |=> !serial_enable;
  endproperty
  a_hw_no_serial: assert property (p_hw_no_serial) else $error("serial on in hw mode");

  property p_serial_on;
    @(posedge clock) disable iff (rst)
      sampled_reg && !strap_reg |=> serial_enable;
  endproperty
  a_serial_on: assert property (p_serial_on) else $error("serial off in serial mode");

  property p_oe_after;
    @(posedge clock) disable iff (rst) sampled_reg |=> config_strap_refout_oe;
  endproperty
  a_oe_after: assert property (p_oe_after) else $error("strap pin not driven");

  property p_hw_cfg;
    @(posedge clock) disable iff (rst)
      load_reg && strap_reg |->
        active_config == cfg_ref_pkg::cfg_sel_t'({1'b0, $past(sel_sync_reg)});
  endproperty
  a_hw_cfg: assert property (p_hw_cfg) else $error("wrong hw config");

  property p_serial_cfg;
    @(posedge clock) disable iff (rst)
      load_reg && !strap_reg |-> active_config ==
        (word0_reg[7] ? cfg_ref_pkg::CFG_I2C_DEFAULT : cfg_ref_pkg::CFG_0);
  endproperty
  a_serial_cfg: assert property (p_serial_cfg) else $error("wrong serial config");

  property p_no_early_change;
    @(posedge clock) disable iff (rst)
      $rose(loaded_reg) ##1 (!settled || !strap_reg) |-> !load_reg;
  endproperty
  a_no_early_change: assert property (p_no_early_change) else $error("early reload");

  // A reload after the boot load is only legal once settled, strapped high and flag clear.
  property p_reload_gated;
    @(posedge clock) disable iff (rst)
      load_reg && $past(loaded_reg) |-> $past(strap_reg) && $past(settled)
        && !$past(word0_reg[`BIT_I2C_DEFAULT]);
  endproperty
  a_reload_gated: assert property (p_reload_gated) else $error("reload not allowed");

  // Writes before the boot load or in hardware mode must leave both registers alone.
  property p_write_refused;
    @(posedge clock) disable iff (rst)
      reg_wr.we && (!loaded_reg || strap_reg) |=> $stable(src_reg) && $stable(word0_reg);
  endproperty
  a_write_refused: assert property (p_write_refused) else $error("write taken");

  property p_mux;
    @(posedge clock) disable iff (rst)
      !src_reg[3] && !refout_reg && $stable(src_reg) |=> diff_reg == $past(want_diff);
  endproperty
  a_mux: assert property (p_mux) else $error("reference select wrong");

  property p_glitchless;
    @(posedge clock) disable iff (rst) $changed(diff_reg) |-> !$past(refout_reg);
  endproperty
  a_glitchless: assert property (p_glitchless) else $error("switch while high");

  property p_no_early_serial;
    @(posedge clock) disable iff (rst) serial_ready |-> $past(loaded_reg);
  endproperty
  a_no_early_serial: assert property (p_no_early_serial) else $error("serial early");
endmodule

// ===== testbench/host_gpio_model.sv
`timescale 1ns/1ps
module host_gpio_model #(
  parameter int HOLD = 20
) (
  input wire logic clock,
  output logic sel_hi,
  output logic sel_lo
);
  initial begin
    sel_hi = 1'b0;
    sel_lo = 1'b0;
  end
  // Moves one pin at a time, sel_hi first, so the device never sees both select pins change in one edge.
  // After each move the host stays quiet while the new configuration loads.
  task automatic step(input logic [1:0] tgt);
    if (sel_hi !== tgt[1]) begin
      @(negedge clock) sel_hi = tgt[1];
      repeat (HOLD) @(negedge clock);
    end
    if (sel_lo !== tgt[0]) begin
      @(negedge clock) sel_lo = tgt[0];
      repeat (HOLD) @(negedge clock);
    end
  endtask
endmodule

// ===== testbench/tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb;
  logic clock, rst, strap, refout, oe, ref_sel, ref_clk, sel_hi, sel_lo;
  logic ser_en, ser_rdy, strobe, diff, strap_pin;
  logic [7:0] word0, insrc;
  logic [1:0] seq [4] = '{2'h1, 2'h0, 2'h2, 2'h3};
  cfg_ref_pkg::reg_wr_t wr;
  cfg_ref_pkg::cfg_sel_t cfg;
  int n_errors = 0;
  int tests_run = 0;
  // The external pull on the strap pin wins only while the device is not driving it.
  assign strap_pin = oe ? refout : strap;
  host_gpio_model #(.HOLD(20)) host (.clock(clock), .sel_hi(sel_hi), .sel_lo(sel_lo));
  config_ref_select #(.SETTLE_CYCLES(50)) uut (.clock(clock), .rst(rst),
    .config_strap_refout_in(strap_pin), .config_strap_refout_out(refout),
    .config_strap_refout_oe(oe), .cfg_select_hi(sel_hi), .cfg_select_lo(sel_lo),
    .ref_input_select(ref_sel), .ref_clk_in(ref_clk), .reg_wr(wr),
    .serial_enable(ser_en), .serial_ready(ser_rdy), .load_strobe(strobe),
    .active_config(cfg), .ref_diff_selected(diff), .otp_config_word_zero(word0),
    .input_source_config(insrc));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    wr = '{we: 1'b1, addr: a, wdata: d};
    @(negedge clock);
    wr.we = 1'b0;
    @(negedge clock);
  endtask
  task automatic boot(input logic s, input logic [1:0] pins);
    int n;
    @(negedge clock);
    rst = 1'b1;
    strap = s;
    host.step(pins);
    repeat (3) @(negedge clock);
    rst = 1'b0;
    wr_reg(8'h13, 8'h02);
    n = 0;
    while (strobe !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    `CHK("boot load", 1'b1, strobe)
    repeat (2) @(negedge clock);
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    rst = 1'b1;
    strap = 1'b0;
    ref_sel = 1'b0;
    ref_clk = 1'b0;
    wr = '0;
    boot(1'b0, 2'h0);
    `CHK("serial_enable", 1'b1, ser_en)
    `CHK("strap oe", 1'b1, oe)
    `CHK("serial_ready", 1'b1, ser_rdy)
    `CHK("serial cfg", cfg_ref_pkg::CFG_0, cfg)
    `CHK("insrc reset", 8'h00, insrc)
    ref_clk = 1'b1;
    repeat (3) @(negedge clock);
    `CHK("mirror", 1'b1, strap_pin)
    ref_clk = 1'b0;
    wr_reg(8'h00, 8'h80);
    wr_reg(8'h05, 8'h0C);
    `CHK("word0", 8'h80, word0)
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'h13, {6'h00, i[1], 1'b0});
      ref_sel = i[0];
      repeat (6) @(negedge clock);
      `CHK("insrc", {6'h00, i[1], 1'b0}, insrc)
      `CHK("diff", i[0] ^ i[1], diff)
    end
    // With the upper mode bit set the pin must no longer steer the mux.
    wr_reg(8'h13, 8'h0A);
    ref_sel = 1'b0;
    repeat (6) @(negedge clock);
    `CHK("auto mode", 1'b0, diff)
    boot(1'b1, 2'h2);
    `CHK("hw serial_enable", 1'b0, ser_en)
    `CHK("hw serial_ready", 1'b0, ser_rdy)
    `CHK("hw cfg", cfg_ref_pkg::CFG_2, cfg)
    wr_reg(8'h13, 8'h02);
    `CHK("hw refused", 8'h00, insrc)
    host.step(2'h3);
    `CHK("early change", cfg_ref_pkg::CFG_2, cfg)
    repeat (40) @(negedge clock);
    foreach (seq[k]) begin
      host.step(seq[k]);
      `CHK("hw select", {1'b0, seq[k]}, cfg)
    end
    tally_and_finish();
  end
endmodule
